/* File: inc/lan_filter_pkg.sv */
// types shared by both ends of the lan filter link
// assumes lan_filter_regs.svh supplies all numeric constants
package lan_filter_pkg;

  typedef struct packed {
    logic [47:0] station;
    logic [63:0] mcast;
    logic enable;
    logic [1:0] bank;
    logic swap;
    logic [13:0] cd_cnt;
    logic cd_run;
    logic [6:0] pending;
    logic tx_go;
    logic [15:0] rdata;
    logic buf_wr;
    logic buf_rd;
    logic [15:0] buf_wdata;
    logic accept;
    logic accept_valid;
  } dev_state_s;

  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_GRAB} host_phase_e;

  typedef struct packed {
    host_phase_e phase;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic word;
    logic [15:0] result;
    logic [15:0] sw_rdata;
  } host_state_s;

endpackage

/* File: inc/lan_filter_regs.svh */
// register offsets, field positions and constants of the lan filter link
// assumes a 4-bit register address on the link and 16-bit host data
`ifndef LAN_FILTER_REGS_SVH
`define LAN_FILTER_REGS_SVH

// -----------------------------------------------------------------
// device register map
// -----------------------------------------------------------------
`define REG_ENABLE 4'h6
`define REG_BANK 4'h7
`define REG_PORT 4'h8
`define REG_TXCNT 4'hA
`define REG_STATION_LAST 4'hD
`define REG_CD_LO 4'hE
`define REG_CD_HI 4'hF
`define ENABLE_BIT 7
`define BANK_MSB 3
`define BANK_LSB 2
`define SWAP_BIT 0
`define TX_GO_BIT 7
`define BANK_STATION 2'h0
`define BANK_MCAST 2'h1
`define BANK_BUFFER 2'h2

// -----------------------------------------------------------------
// receive filter
// -----------------------------------------------------------------
`define MCAST_BIT 0
`define CRC_POLY 32'hEDB88320
`define CRC_INIT 32'hFFFFFFFF
`define MODE_REJECT 2'h0
`define MODE_ALL_MCAST 2'h1
`define MODE_HASH 2'h2
`define MODE_PROMISC 2'h3

// -----------------------------------------------------------------
// host end command registers
// -----------------------------------------------------------------
`define HOST_CMD 2'h0
`define HOST_WDATA 2'h1
`define HOST_STATUS 2'h2
`define HOST_RDATA 2'h3
`define CMD_WORD_BIT 4
`define CMD_READ_BIT 5

`endif

/* File: inc/lan_link_if.sv */
// register link between host end and device end
// assumes both ends run on the same core clock
`timescale 1ns/10ps
interface lan_link_if;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic wr;
  logic rd;
  logic word;

  modport dev (input addr, input wdata, input wr, input rd, input word, output rdata);
  modport host (output addr, output wdata, output wr, output rd, output word, input rdata);
endinterface

/* File: rtl/lan_filter_dev.sv */
// device end: station address, multicast hash, collision distance,
// buffer data port and transmit start/count registers
// assumes link strobes are synchronous to core_clk_i and single-cycle
`timescale 1ns/10ps
`include "lan_filter_regs.svh"
module lan_filter_dev (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  lan_link_if.dev link,
  input wire logic bus16_i,
  input wire logic [1:0] match_mode_i,
  input wire logic [47:0] dest_addr_i,
  input wire logic dest_valid_i,
  input wire logic tx_start_i,
  input wire logic tx_bit_i,
  input wire logic collision_i,
  input wire logic carrier_i,
  input wire logic tx_frame_done_i,
  input wire logic [15:0] buf_rdata_i,
  output logic buf_wr_o,
  output logic [15:0] buf_wdata_o,
  output logic buf_rd_o,
  output logic transmit_go_o,
  output logic [6:0] pending_frame_count_o,
  output logic frame_accept_o,
  output logic frame_accept_valid_o
);
  import lan_filter_pkg::*;

  dev_state_s s;
  dev_state_s next_s;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // ethernet crc, lsb first, no final inversion
  function automatic logic [31:0] crc_of(input logic [47:0] d);
    logic [31:0] c;
    c = `CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? `CRC_POLY : 32'h0);
    end
    return c;
  endfunction

  function automatic logic [7:0] rd_byte(input dev_state_s t, input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `REG_ENABLE) begin
      v[`ENABLE_BIT] = t.enable;
    end else if (a == `REG_BANK) begin
      v[`BANK_MSB:`BANK_LSB] = t.bank;
      v[`SWAP_BIT] = t.swap;
    end else if (a[3]) begin
      case (t.bank)
        `BANK_STATION: begin
          if (a == `REG_CD_LO) begin
            v = t.cd_cnt[7:0];
          end else if (a == `REG_CD_HI) begin
            v = {2'b00, t.cd_cnt[13:8]};
          end else if (t.enable) begin
            v = t.station[{a[2:0], 3'b000} +: 8];
          end
        end
        `BANK_MCAST: begin
          if (t.enable) begin
            v = t.mcast[{a[2:0], 3'b000} +: 8];
          end
        end
        `BANK_BUFFER: begin
          if (a == `REG_TXCNT) begin
            v = {1'b0, t.pending};
          end
        end
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  // the collision distance registers have no write path at all
  function automatic dev_state_s wr_byte(input dev_state_s t, input logic [3:0] a,
                                         input logic [7:0] v);
    dev_state_s r;
    r = t;
    if (a == `REG_ENABLE) begin
      r.enable = v[`ENABLE_BIT];
    end else if (a == `REG_BANK) begin
      r.bank = v[`BANK_MSB:`BANK_LSB];
      r.swap = v[`SWAP_BIT];
    end else if (a[3]) begin
      case (t.bank)
        `BANK_STATION: begin
          if (t.enable && a <= `REG_STATION_LAST) begin
            r.station[{a[2:0], 3'b000} +: 8] = v;
          end
        end
        `BANK_MCAST: begin
          if (t.enable) begin
            r.mcast[{a[2:0], 3'b000} +: 8] = v;
          end
        end
        `BANK_BUFFER: begin
          // writing zero in the go bit leaves the count untouched
          if (a == `REG_TXCNT && v[`TX_GO_BIT]) begin
            r.pending = v[6:0];
            r.tx_go = 1'b1;
          end
        end
        default: r = t;
      endcase
    end
    return r;
  endfunction

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  logic is_port;
  logic do_swap;
  logic [31:0] crc;
  logic is_mcast;
  logic station_hit;
  logic hash_hit;

  always_comb begin
    is_port = (s.bank == `BANK_BUFFER) && (link.addr == `REG_PORT);
    do_swap = bus16_i && s.swap;
    crc = crc_of(dest_addr_i);
    is_mcast = dest_addr_i[`MCAST_BIT];
    station_hit = (dest_addr_i == s.station);
    hash_hit = s.mcast[crc[5:0]];

    next_s = s;
    next_s.tx_go = 1'b0;
    next_s.buf_wr = 1'b0;
    next_s.buf_rd = 1'b0;
    next_s.accept_valid = 1'b0;
    next_s.rdata = 16'h0000;

    // collision distance: cleared on start, frozen on collision or carrier loss
    if (tx_start_i) begin
      next_s.cd_cnt = 14'h0000;
      next_s.cd_run = 1'b1;
    end else if (s.cd_run) begin
      if (collision_i || !carrier_i) begin
        next_s.cd_run = 1'b0;
      end else if (tx_bit_i) begin
        next_s.cd_cnt = s.cd_cnt + 14'h0001;
      end
    end

    if (tx_frame_done_i && s.pending != 7'h00) begin
      next_s.pending = s.pending - 7'h01;
    end

    if (dest_valid_i) begin
      next_s.accept_valid = 1'b1;
      case (match_mode_i)
        `MODE_REJECT: next_s.accept = 1'b0;
        `MODE_ALL_MCAST: next_s.accept = is_mcast || station_hit;
        `MODE_HASH: next_s.accept = is_mcast ? hash_hit : station_hit;
        default: next_s.accept = 1'b1;
      endcase
    end

    // host write; a new count overrides a same-cycle decrement
    if (link.wr) begin
      if (is_port) begin
        if (!bus16_i) begin
          next_s.buf_wr = 1'b1;
          next_s.buf_wdata = {8'h00, link.wdata[7:0]};
        end else if (link.word) begin
          next_s.buf_wr = 1'b1;
          next_s.buf_wdata = do_swap ? {link.wdata[7:0], link.wdata[15:8]}
                                     : link.wdata;
        end
      end else begin
        next_s = wr_byte(next_s, link.addr, link.wdata[7:0]);
        if (bus16_i && link.word) begin
          next_s = wr_byte(next_s, link.addr | 4'h1, link.wdata[15:8]);
        end
      end
    end

    // read data registered, valid in the following cycle
    if (link.rd) begin
      if (is_port) begin
        if (!bus16_i) begin
          next_s.buf_rd = 1'b1;
          next_s.rdata = {8'h00, buf_rdata_i[7:0]};
        end else if (link.word) begin
          next_s.buf_rd = 1'b1;
          next_s.rdata = do_swap ? {buf_rdata_i[7:0], buf_rdata_i[15:8]}
                                 : buf_rdata_i;
        end
      end else begin
        next_s.rdata[7:0] = rd_byte(s, link.addr);
        if (bus16_i && link.word) begin
          next_s.rdata[15:8] = rd_byte(s, link.addr | 4'h1);
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  // address and filter contents have no defined reset; zero is used
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.rdata = s.rdata;
  assign buf_wr_o = s.buf_wr;
  assign buf_wdata_o = s.buf_wdata;
  assign buf_rd_o = s.buf_rd;
  assign transmit_go_o = s.tx_go;
  assign pending_frame_count_o = s.pending;
  assign frame_accept_o = s.accept;
  assign frame_accept_valid_o = s.accept_valid;
endmodule

/* File: rtl/lan_filter_host.sv */
// host end: software command registers turned into single link accesses
// assumes the device answers a read in the cycle after the strobe
`timescale 1ns/10ps
`include "lan_filter_regs.svh"
module lan_filter_host (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  lan_link_if.host link,
  input wire logic [1:0] sw_addr_i,
  input wire logic [15:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [15:0] sw_rdata_o
);
  import lan_filter_pkg::*;

  host_state_s s;
  host_state_s next_s;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    next_s.sw_rdata = 16'h0000;

    case (s.phase)
      H_WAIT: next_s.phase = H_GRAB;
      H_GRAB: begin
        next_s.result = link.rdata;
        next_s.phase = H_IDLE;
      end
      default: next_s.phase = H_IDLE;
    endcase

    if (sw_wr_i) begin
      if (sw_addr_i == `HOST_WDATA) begin
        next_s.wdata = sw_wdata_i;
      end else if (sw_addr_i == `HOST_CMD && s.phase == H_IDLE) begin
        // commands while busy are dropped; software polls status first
        next_s.addr = sw_wdata_i[3:0];
        next_s.word = sw_wdata_i[`CMD_WORD_BIT];
        if (sw_wdata_i[`CMD_READ_BIT]) begin
          next_s.rd = 1'b1;
          next_s.phase = H_WAIT;
        end else begin
          // start and address writes are software ordered
          next_s.wr = 1'b1;
        end
      end
    end

    if (sw_rd_i) begin
      if (sw_addr_i == `HOST_CMD) begin
        next_s.sw_rdata = {10'h000, s.word, 1'b0, s.addr};
      end else if (sw_addr_i == `HOST_WDATA) begin
        next_s.sw_rdata = s.wdata;
      end else if (sw_addr_i == `HOST_STATUS) begin
        next_s.sw_rdata = {15'h0000, s.phase != H_IDLE};
      end else begin
        next_s.sw_rdata = s.result;
      end
    end
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.addr = s.addr;
  assign link.wdata = s.wdata;
  assign link.wr = s.wr;
  assign link.rd = s.rd;
  assign link.word = s.word;
  assign sw_rdata_o = s.sw_rdata;
endmodule

/* File: sim/lan_addr_filter_tx_port_regs_test.sv */
// bench: host and device ends joined by the link, driven at the software port
// assumes the host end turns one command into one link access
`timescale 1ns/10ps
`include "lan_filter_regs.svh"
`define CHK(n, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("Error %s exp %h got %h", n, e, g); \
  end \
end
module lan_addr_filter_tx_port_regs_test;
  import lan_filter_pkg::*;
  localparam logic [47:0] ST = 48'hA1B2C3D4E5F6;
  localparam logic [47:0] MC = ST | 48'h1;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0;
  logic [1:0] sw_addr = 2'h0, mode = 2'h0;
  logic [15:0] sw_wdata = 16'h0, sw_rdata, buf_wdata, buf_rdata = 16'hABCD;
  logic sw_wr = 1'b0, sw_rd = 1'b0, bus16 = 1'b1, dest_v = 1'b0, tx_start = 1'b0;
  logic tx_bit = 1'b0, coll = 1'b0, carrier = 1'b1, done = 1'b0;
  logic buf_wr, buf_rd, go, acc_f, acc_v;
  logic [47:0] dest = 48'h0;
  logic [6:0] pending;
  logic [5:0] g;
  int error_cnt = 0, comparisons = 0, wr_cnt = 0, go_cnt = 0, rd_cnt = 0;
  initial forever #25 core_clk_i = ~core_clk_i;
  lan_link_if lan_link_if_i ();
  lan_filter_host lan_filter_host_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .link(lan_link_if_i), .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr),
    .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata));
  lan_filter_dev lan_filter_dev_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .link(lan_link_if_i), .bus16_i(bus16), .match_mode_i(mode), .dest_addr_i(dest),
    .dest_valid_i(dest_v), .tx_start_i(tx_start), .tx_bit_i(tx_bit), .collision_i(coll),
    .carrier_i(carrier), .tx_frame_done_i(done), .buf_rdata_i(buf_rdata),
    .buf_wr_o(buf_wr), .buf_wdata_o(buf_wdata), .buf_rd_o(buf_rd), .transmit_go_o(go),
    .pending_frame_count_o(pending), .frame_accept_o(acc_f), .frame_accept_valid_o(acc_v));
  lan_filter_asserts lan_filter_asserts_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .addr(lan_link_if_i.addr), .wdata(lan_link_if_i.wdata), .rdata(lan_link_if_i.rdata),
    .wr(lan_link_if_i.wr), .rd(lan_link_if_i.rd), .word(lan_link_if_i.word));
  // pulses counted mid-cycle, away from the edge that launches them
  always @(negedge core_clk_i) begin
    if (buf_wr) wr_cnt++;
    if (buf_rd) rd_cnt++;
    if (go) go_cnt++;
  end
  // ---------------------------------------------------------------
  // software port accesses
  // ---------------------------------------------------------------
  task automatic sw(input logic [1:0] a, input logic [15:0] d, input logic r);
    @(posedge core_clk_i);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= !r;
    sw_rd <= r;
    @(posedge core_clk_i);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    @(negedge core_clk_i);
  endtask
  // wait covers the busy window, a command while busy would be dropped
  task automatic acc(input logic [5:0] c, input logic [15:0] d);
    sw(2'h1, d, 1'b0);
    sw(2'h0, {10'h0, c}, 1'b0);
    repeat (4) @(posedge core_clk_i);
    if (c[5]) sw(2'h3, 16'h0, 1'b1);
  endtask
  task automatic chk_rd(input logic [5:0] c, input logic [15:0] e);
    acc(c | 6'h20, 16'h0);
    `CHK("rdata", e, sw_rdata)
  endtask
  task automatic frame(input logic [1:0] m, input logic [47:0] a, input logic e);
    @(posedge core_clk_i);
    mode <= m;
    dest <= a;
    dest_v <= 1'b1;
    @(posedge core_clk_i);
    dest_v <= 1'b0;
    @(negedge core_clk_i);
    `CHK("accept_valid", 1'b1, acc_v)
    `CHK("accept", e, acc_f)
  endtask
  task automatic txrun(input int n, input logic c);
    @(posedge core_clk_i) tx_start <= 1'b1;
    @(posedge core_clk_i) tx_start <= 1'b0;
    for (int i = 0; i < n + 4; i++) begin
      @(posedge core_clk_i) tx_bit <= 1'b1;
      @(posedge core_clk_i) tx_bit <= 1'b0;
      coll <= (i >= n - 1) ? c : 1'b0;
      carrier <= (i >= n - 1) ? c : 1'b1;
    end
    @(posedge core_clk_i) coll <= 1'b0;
    carrier <= 1'b1;
  endtask
  task automatic setmc(input logic inv);
    for (int j = 0; j < 8; j++)
      acc(6'(8 + j), {8'h0, ((j == g[5:3]) ? (8'h01 << g[2:0]) : 8'h00) ^ {8{inv}}});
  endtask
  function automatic logic [5:0] crc6(input logic [47:0] a);
    logic [31:0] c;
    c = `CRC_INIT;
    for (int i = 0; i < 48; i++) c = (c >> 1) ^ ((c[0] ^ a[i]) ? `CRC_POLY : 32'h0);
    return c[5:0];
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk_i);
    error_cnt++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    g = crc6(MC);
    repeat (10) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    chk_rd(6'h08, 16'h0);
    acc(6'h08, 16'h0055);
    acc(6'h06, 16'h0080);
    chk_rd(6'h08, 16'h0);
    for (int i = 0; i < 6; i++) acc(6'(8 + i), {8'h0, ST[8*i +: 8]});
    chk_rd(6'h0D, {8'h0, ST[47:40]});
    chk_rd(6'h18, ST[15:0]);
    sw(2'h0, 16'h0038, 1'b0);
    sw(2'h2, 16'h0, 1'b1);
    `CHK("busy", 16'h0001, sw_rdata)
    repeat (4) @(posedge core_clk_i);
    sw(2'h2, 16'h0, 1'b1);
    `CHK("busy", 16'h0000, sw_rdata)
    sw(2'h3, 16'h0, 1'b1);
    `CHK("rdata", ST[15:0], sw_rdata)
    frame(`MODE_REJECT, ST, 1'b0);
    frame(`MODE_HASH, ST, 1'b1);
    frame(`MODE_HASH, ST ^ 48'h100, 1'b0);
    frame(`MODE_ALL_MCAST, MC, 1'b1);
    frame(`MODE_PROMISC, 48'h0, 1'b1);
    acc(6'h07, 16'h0004);
    setmc(1'b0);
    frame(`MODE_HASH, MC, 1'b1);
    setmc(1'b1);
    frame(`MODE_HASH, MC, 1'b0);
    chk_rd(6'(8 + g[5:3]), {8'h0, ~(8'h01 << g[2:0])});
    $display("test filter done");
    acc(6'h07, 16'h0000);
    txrun(300, 1'b1);
    chk_rd(6'h0E, 16'h002C);
    chk_rd(6'h0F, 16'h0001);
    acc(6'h0E, 16'h00FF);
    chk_rd(6'h0E, 16'h002C);
    txrun(5, 1'b0);
    chk_rd(6'h0E, 16'h0005);
    $display("test counter done");
    acc(6'h07, 16'h0008);
    acc(6'h18, 16'h1234);
    `CHK("buf_wdata", 16'h1234, buf_wdata)
    acc(6'h07, 16'h0009);
    acc(6'h18, 16'h1234);
    `CHK("buf_wdata", 16'h3412, buf_wdata)
    acc(6'h08, 16'h00AA);
    `CHK("wr_cnt", 2, wr_cnt)
    chk_rd(6'h18, 16'hCDAB);
    chk_rd(6'h08, 16'h0000);
    `CHK("rd_cnt", 1, rd_cnt)
    @(posedge core_clk_i) bus16 <= 1'b0;
    acc(6'h08, 16'h005A);
    `CHK("buf_wdata", 16'h005A, buf_wdata)
    `CHK("wr_cnt", 3, wr_cnt)
    chk_rd(6'h08, 16'h00CD);
    `CHK("rd_cnt", 2, rd_cnt)
    @(posedge core_clk_i) bus16 <= 1'b1;
    $display("test port done");
    acc(6'h0A, 16'h0083);
    `CHK("go_cnt", 1, go_cnt)
    `CHK("pending", 7'h03, pending)
    chk_rd(6'h0A, 16'h0003);
    repeat (2) begin
      @(posedge core_clk_i) done <= 1'b1;
      @(posedge core_clk_i) done <= 1'b0;
    end
    @(negedge core_clk_i);
    `CHK("pending", 7'h01, pending)
    acc(6'h0A, 16'h0005);
    `CHK("pending", 7'h01, pending)
    `CHK("go_cnt", 1, go_cnt)
    @(posedge core_clk_i) done <= 1'b1;
    @(posedge core_clk_i) done <= 1'b0;
    @(negedge core_clk_i);
    `CHK("pending", 7'h00, pending)
    acc(6'h07, 16'h000C);
    chk_rd(6'h08, 16'h0);
    $display("test transmit done");
    wrap_up();
  end
endmodule

/* File: sim/lan_filter_asserts.sv */
// checker of the register link between host end and device end
// assumes byte accesses to the enable and bank registers
`timescale 1ns/10ps
`include "lan_filter_regs.svh"
module lan_filter_asserts (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic word
);
  logic en;
  logic [1:0] bank;
  // ---------------------------------------------------------------
  // shadow of enable and bank, tracked from link writes
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      en <= 1'b0;
      bank <= 2'h0;
    end else if (wr && addr == `REG_ENABLE) begin
      en <= wdata[`ENABLE_BIT];
    end else if (wr && addr == `REG_BANK) begin
      bank <= wdata[`BANK_MSB:`BANK_LSB];
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_one_strobe; !(wr && rd); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("wr and rd together");
  property p_rd_pulse; rd |=> !rd; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("rd longer than one cycle");
  property p_wr_pulse; $rose(wr) |=> !wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("wr longer than one cycle");
  property p_rdata_idle; !rd |=> rdata == 16'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("rdata outside answer");
  property p_locked;
    rd && !en && addr[3] && (bank == `BANK_MCAST ||
      (bank == `BANK_STATION && addr <= `REG_STATION_LAST)) |=> rdata == 16'h0;
  endproperty
  a_locked: assert property (p_locked) else $error("locked register read");
  property p_cd_hi; rd && bank == `BANK_STATION && addr == `REG_CD_HI |=> rdata[7:6] == 2'h0;
  endproperty
  a_cd_hi: assert property (p_cd_hi) else $error("count top bits set");
  property p_go_zero; rd && bank == `BANK_BUFFER && addr == `REG_TXCNT |=> !rdata[`TX_GO_BIT];
  endproperty
  a_go_zero: assert property (p_go_zero) else $error("start bit read as one");
  property p_bank3; rd && bank == 2'h3 && addr[3] |=> rdata == 16'h0; endproperty
  a_bank3: assert property (p_bank3) else $error("bank three not empty");
  c_locked: cover property (rd && !en && addr[3]);
  c_go: cover property (rd && bank == `BANK_BUFFER && addr == `REG_TXCNT);
  c_word: cover property (wr && word && bank == `BANK_BUFFER);
endmodule
